// >>> common/gbi2c_cfg.svh
`ifndef GBI2C_CFG_SVH
`define GBI2C_CFG_SVH
// ---------------------------------------------------------------
// register map and link constants
// ---------------------------------------------------------------
`define GBI2C_CTRL_ADDR      8'h00  // control register offset
`define GBI2C_FIRST_ENTRY    8'h01  // first gamma entry of a bank
`define GBI2C_LAST_ENTRY     8'h0E  // last gamma entry of a bank
`define GBI2C_ENTRIES        14     // entries per bank
`define GBI2C_CTRL_RESET     8'h00  // control byte after reset
`define GBI2C_WBANK_BIT      1      // write bank select position
`define GBI2C_RBANK_BIT      2      // read bank select position
`define GBI2C_INVALID_BYTE   8'hFF  // fill for reads past the bank
`define GBI2C_ADDR_UPPER     5'h1D  // fixed upper slave address bits
`define GBI2C_FIFO_DEPTH     16     // write data buffer depth
`endif

// >>> common/gbi2c_pkg.sv
`default_nettype none
package gbi2c_pkg;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    GB_IDLE  = 8'h01,  // waiting for start
    GB_ADDR  = 8'h02,  // shifting slave address
    GB_AACK  = 8'h04,  // acknowledging address
    GB_WRX   = 8'h08,  // shifting a written byte
    GB_WACK  = 8'h10,  // acknowledging a written byte
    GB_RTX   = 8'h20,  // shifting a read byte out
    GB_RACK  = 8'h40,  // sampling master acknowledge
    GB_SKIP  = 8'h80   // not addressed or read nacked, wait for stop
  } gbi2c_state_e;

  typedef struct packed {
    logic       bank;   // target bank, 1 = bank b
    logic [3:0] index;  // entry index 0..13
    logic [7:0] data;   // byte to store
  } gbi2c_wr_s;

  typedef struct packed {
    logic read_bank;    // read bank select
    logic write_bank;   // write bank select
  } gbi2c_bank_s;
endpackage
`default_nettype wire

// >>> rtl/gbi2c_fifo.sv
`default_nettype none
// ---------------------------------------------------------------
// write buffer between link and bank memory
// ---------------------------------------------------------------
module gbi2c_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // storage
  logic [AW-1:0]    wp_q, wp_d;     // write pointer
  logic [AW-1:0]    rp_q, rp_d;     // read pointer
  logic [AW:0]      cnt_q, cnt_d;   // fill level
  logic             push, pop;      // accepted transfers

  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rp_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // pointer and level update
  always_comb
  begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // registers
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push)
      mem_q[wp_q] <= i_in_data;
  end
endmodule
`default_nettype wire

// >>> rtl/gbi2c_slave.sv
`include "gbi2c_cfg.svh"
`default_nettype none
module gbi2c_slave #(
  parameter int FIFO_DEPTH = `GBI2C_FIFO_DEPTH
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  output logic                      o_sda_out,
  output logic                      o_sda_oe,
  input  wire logic                 i_transfer_mode_select,
  input  wire logic                 i_address_select_high,
  input  wire logic                 i_address_select_low,
  output gbi2c_pkg::gbi2c_bank_s    o_bank,
  output logic [8*`GBI2C_ENTRIES-1:0] o_bank_a,
  output logic [8*`GBI2C_ENTRIES-1:0] o_bank_b
);
  import gbi2c_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_q, sda_sync_q;  // two stages each
  logic       scl_q, sda_q;            // previous synced level
  logic       mode_m_q, mode_q;        // mode select synced
  logic [1:0] asel_m_q, asel_q;        // address select synced
  logic       scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      mode_m_q   <= 1'b0;
      mode_q     <= 1'b0;
      asel_m_q   <= 2'h0;
      asel_q     <= 2'h0;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
      mode_m_q   <= i_transfer_mode_select;
      mode_q     <= mode_m_q;
      asel_m_q   <= {i_address_select_high, i_address_select_low};
      asel_q     <= asel_m_q;
    end
  end

  assign scl_rise  = scl_sync_q[1] & ~scl_q;
  assign scl_fall  = ~scl_sync_q[1] & scl_q;
  assign start_det = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  assign stop_det  = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true when the pointer names a gamma entry
  function automatic logic entry_ok(input logic [7:0] a);
    entry_ok = (a >= `GBI2C_FIRST_ENTRY) && (a <= `GBI2C_LAST_ENTRY);
  endfunction

  // pointer to entry index
  function automatic logic [3:0] entry_idx(input logic [7:0] a);
    logic [7:0] t;
    t = a - `GBI2C_FIRST_ENTRY;
    entry_idx = t[3:0];
  endfunction

  // ---------------------------------------------------------------
  // protocol state
  // ---------------------------------------------------------------
  gbi2c_state_e st_q, st_d;       // link state
  logic [7:0]   sh_q, sh_d;       // shift register
  logic [3:0]   bit_q, bit_d;     // bit counter
  logic [7:0]   ptr_q, ptr_d;     // register pointer
  logic         first_q, first_d; // next written byte is first of frame
  logic         rw_q, rw_d;       // direction of current frame
  logic         oe_q, oe_d;       // drive sda low
  logic [7:0]   ctrl_q, ctrl_d;   // control register
  logic         wr_valid;         // byte to push into buffer
  gbi2c_wr_s    wr_word;          // buffered write
  logic         wr_ready;         // buffer has room
  logic [7:0]   rd_byte;          // byte presented on a read

  // read data: control, entry of read bank, or fill
  always_comb
  begin
    if (ptr_q == `GBI2C_CTRL_ADDR)
      rd_byte = ctrl_q;
    else if (entry_ok(ptr_q))
      rd_byte = ctrl_q[`GBI2C_RBANK_BIT] ? o_bank_b[entry_idx(ptr_q)*8 +: 8]
                                         : o_bank_a[entry_idx(ptr_q)*8 +: 8];
    else
      rd_byte = `GBI2C_INVALID_BYTE;
  end

  // next state of the link engine
  always_comb
  begin
    st_d     = st_q;
    sh_d     = sh_q;
    bit_d    = bit_q;
    ptr_d    = ptr_q;
    first_d  = first_q;
    rw_d     = rw_q;
    oe_d     = oe_q;
    ctrl_d   = ctrl_q;
    wr_valid = 1'b0;
    wr_word  = '0;
    if (stop_det)
    begin
      st_d = GB_IDLE;
      oe_d = 1'b0;
    end
    else if (start_det)
    begin
      // repeated start keeps the pointer for register reads
      st_d  = GB_ADDR;
      bit_d = 4'h0;
      oe_d  = 1'b0;
    end
    else
    begin
      case (st_q)
        GB_IDLE, GB_SKIP:
        begin
          oe_d = 1'b0;
        end
        GB_ADDR, GB_WRX:
        begin
          if (scl_rise)
          begin
            sh_d  = {sh_q[6:0], sda_q};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8)
          begin
            bit_d = 4'h0;
            if (st_q == GB_ADDR)
            begin
              if (sh_q[7:1] == {`GBI2C_ADDR_UPPER, asel_q})
              begin
                st_d    = GB_AACK;
                oe_d    = 1'b1;
                rw_d    = sh_q[0];
                first_d = ~sh_q[0];
                if (sh_q[0] && mode_q)
                  ptr_d = `GBI2C_FIRST_ENTRY;
              end
              else
                st_d = GB_SKIP;
            end
            else
            begin
              st_d    = GB_WACK;
              oe_d    = 1'b1;
              first_d = 1'b0;
              if (first_q && (!mode_q || sh_q == `GBI2C_CTRL_ADDR) && !(mode_q))
                ptr_d = sh_q;
              else if (first_q && mode_q)
              begin
                // standard mode: first byte is the control byte
                ctrl_d = sh_q;
                ptr_d  = `GBI2C_FIRST_ENTRY;
              end
              else if (ptr_q == `GBI2C_CTRL_ADDR)
              begin
                ctrl_d = sh_q;
                ptr_d  = `GBI2C_FIRST_ENTRY;
              end
              else
              begin
                if (entry_ok(ptr_q) && wr_ready)
                begin
                  wr_valid      = 1'b1;
                  wr_word.bank  = ctrl_q[`GBI2C_WBANK_BIT];
                  wr_word.index = entry_idx(ptr_q);
                  wr_word.data  = sh_q;
                end
                if (ptr_q != 8'hFF)
                  ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        GB_AACK, GB_WACK:
        begin
          if (scl_fall)
          begin
            if (st_q == GB_AACK && rw_q)
            begin
              st_d  = GB_RTX;
              sh_d  = rd_byte;
              oe_d  = ~rd_byte[7];
              bit_d = 4'h1;
            end
            else
            begin
              st_d = GB_WRX;
              oe_d = 1'b0;
            end
          end
        end
        GB_RTX:
        begin
          if (scl_fall)
          begin
            if (bit_q == 4'h8)
            begin
              st_d  = GB_RACK;
              oe_d  = 1'b0;
              bit_d = 4'h0;
              if (ptr_q != 8'hFF)
                ptr_d = ptr_q + 8'h01;
            end
            else
            begin
              oe_d  = ~sh_q[6];
              sh_d  = {sh_q[6:0], 1'b0};
              bit_d = bit_q + 4'h1;
            end
          end
        end
        GB_RACK:
        begin
          if (scl_rise)
            st_d = sda_q ? GB_SKIP : GB_RACK;
          if (scl_fall)
          begin
            st_d  = GB_RTX;
            sh_d  = rd_byte;
            oe_d  = ~rd_byte[7];
            bit_d = 4'h1;
          end
        end
        default:
        begin
          st_d = GB_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // link registers
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st_q    <= GB_IDLE;
      sh_q    <= 8'h00;
      bit_q   <= 4'h0;
      ptr_q   <= `GBI2C_FIRST_ENTRY;
      first_q <= 1'b0;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
      ctrl_q  <= `GBI2C_CTRL_RESET;
    end
    else
    begin
      st_q    <= st_d;
      sh_q    <= sh_d;
      bit_q   <= bit_d;
      ptr_q   <= ptr_d;
      first_q <= first_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      ctrl_q  <= ctrl_d;
    end
  end

  assign o_sda_out         = 1'b0;
  assign o_sda_oe          = oe_q;
  assign o_bank.read_bank  = ctrl_q[`GBI2C_RBANK_BIT];
  assign o_bank.write_bank = ctrl_q[`GBI2C_WBANK_BIT];

  // ---------------------------------------------------------------
  // write buffer and bank storage
  // ---------------------------------------------------------------
  logic      bf_valid;  // buffered write waiting
  gbi2c_wr_s bf_word;   // buffered write
  logic [8*`GBI2C_ENTRIES-1:0] bank_a_q, bank_a_d, bank_b_q, bank_b_d;

  gbi2c_fifo #(
    .WIDTH ($bits(gbi2c_wr_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (wr_valid),
    .o_in_ready  (wr_ready),
    .i_in_data   (wr_word),
    .o_out_valid (bf_valid),
    .i_out_ready (1'b1),
    .o_out_data  (bf_word)
  );

  // drain one buffered write per cycle into the selected bank
  always_comb
  begin
    bank_a_d = bank_a_q;
    bank_b_d = bank_b_q;
    if (bf_valid)
    begin
      if (bf_word.bank)
        bank_b_d[bf_word.index*8 +: 8] = bf_word.data;
      else
        bank_a_d[bf_word.index*8 +: 8] = bf_word.data;
    end
  end

  // bank registers
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      bank_a_q <= '0;
      bank_b_q <= '0;
    end
    else
    begin
      bank_a_q <= bank_a_d;
      bank_b_q <= bank_b_d;
    end
  end

  assign o_bank_a = bank_a_q;
  assign o_bank_b = bank_b_q;
endmodule
`default_nettype wire

// >>> tb/gbi2c_slave_asserts.sv
`include "gbi2c_cfg.svh"
`default_nettype none
// --------------------
// port checker for the slave
// --------------------
module gbi2c_slave_asserts (
  input wire logic                        i_clock,
  input wire logic                        i_rst,
  input wire logic                        i_scl,
  input wire logic                        o_sda_out,
  input wire logic                        o_sda_oe,
  input wire gbi2c_pkg::gbi2c_bank_s      o_bank,
  input wire logic [8*`GBI2C_ENTRIES-1:0] o_bank_a,
  input wire logic [8*`GBI2C_ENTRIES-1:0] o_bank_b
);
  timeunit 1ns;
  timeprecision 1ns;
  import gbi2c_pkg::*;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  logic [5:0] since_q;  // cycles since the slave last took the line
  logic [5:0] since_d;  // next value
  logic       oe_q;     // line enable one cycle back
  // count up from each rise of the line enable, saturating
  always_comb
  begin
    since_d = (since_q == 6'h3F) ? since_q : since_q + 6'h01;
    if (o_sda_oe && !oe_q)
      since_d = 6'h00;
    if (i_rst)
      since_d = 6'h3F;
  end
  // register helper state
  always_ff @(posedge i_clock)
  begin
    since_q <= since_d;
    oe_q    <= o_sda_oe;
  end
  // --------------------
  // sequences and properties
  // --------------------
  sequence s_scl_low;
    !i_scl && !$past(i_scl);
  endsequence
  sequence s_hold;
    o_sda_oe [*6];
  endsequence
  property p_sda_out_low;
    o_sda_out == 1'b0;
  endproperty
  property p_reset_clear;
    $fell(i_rst) |-> o_bank == 2'h0 && o_bank_a == '0 && o_bank_b == '0 && !o_sda_oe;
  endproperty
  property p_oe_rise;
    $rose(o_sda_oe) |-> s_scl_low;
  endproperty
  property p_oe_fall;
    $fell(o_sda_oe) |-> !i_scl;
  endproperty
  property p_oe_steady;
    i_scl && $past(i_scl) |-> $stable(o_sda_oe);
  endproperty
  property p_ack_hold;
    $rose(o_sda_oe) |-> s_hold;
  endproperty
  property p_bank_after_ack;
    $changed(o_bank_a) || $changed(o_bank_b) |-> since_q < 6'h18;
  endproperty
  // control byte lands in the same cycle as its ack is taken
  property p_ctrl_after_ack;
    $changed(o_bank) |-> $rose(o_sda_oe);
  endproperty
  a_sda_out_low: assert property (p_sda_out_low)
    else $error("sda data value not low");
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not clear after reset");
  a_oe_rise: assert property (p_oe_rise)
    else $error("slave took sda while scl high");
  a_oe_fall: assert property (p_oe_fall)
    else $error("slave let go of sda while scl high");
  a_oe_steady: assert property (p_oe_steady)
    else $error("sda enable moved while scl high");
  a_ack_hold: assert property (p_ack_hold)
    else $error("slave bit held too briefly");
  a_bank_after_ack: assert property (p_bank_after_ack)
    else $error("bank changed away from an ack");
  a_ctrl_after_ack: assert property (p_ctrl_after_ack)
    else $error("bank select changed away from an ack");
endmodule
bind gbi2c_slave gbi2c_slave_asserts u_gbi2c_slave_asserts (
  .i_clock   (i_clock),
  .i_rst     (i_rst),
  .i_scl     (i_scl),
  .o_sda_out (o_sda_out),
  .o_sda_oe  (o_sda_oe),
  .o_bank    (o_bank),
  .o_bank_a  (o_bank_a),
  .o_bank_b  (o_bank_b)
);
`default_nettype wire

// >>> tb/gbi2c_master_model.sv
`default_nettype none
// --------------------
// i2c bus master, open drain on sda
// --------------------
module gbi2c_master_model (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle: both lines high
  initial
  begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  // wait whole clock periods
  task automatic w(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // start or repeated start, scl ends low
  task automatic start();
    w(2);
    o_sda_low = 1'b0;
    w(4);
    o_scl = 1'b1;
    w(6);
    o_sda_low = 1'b1;
    w(6);
    o_scl = 1'b0;
  endtask
  // stop ends every transfer
  task automatic stop();
    w(2);
    o_sda_low = 1'b1;
    w(4);
    o_scl = 1'b1;
    w(6);
    o_sda_low = 1'b0;
    w(6);
  endtask
  // one bit, data moves only while scl low
  task automatic bit_x(input logic b, output logic r);
    w(2);
    o_sda_low = !b;
    w(4);
    o_scl = 1'b1;
    w(6);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  // eight bits msb first, then the ack slot
  task automatic byte_x(input logic [7:0] b, input logic a,
                        output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], r[i]);
    bit_x(a, ak);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_gbi2c_slave.sv
`include "gbi2c_cfg.svh"
`default_nettype none
module tb_gbi2c_slave;
  timeunit 1ns;
  timeprecision 1ns;
  import gbi2c_pkg::*;
  // --------------------
  // signals and expected state
  // --------------------
  logic                        i_clock;     // 25 mhz
  logic                        i_rst;       // sync reset
  logic                        mode;        // 1 standard, 0 register
  logic                        scl;         // master clock line
  logic                        sda_low;     // master pulls sda
  logic                        sda_oe;      // slave pulls sda
  logic                        sda_out;     // slave data value
  wire logic                   sda;         // wired bus, pulled up
  gbi2c_bank_s                 bank;        // bank selects
  logic [8*`GBI2C_ENTRIES-1:0] bank_a;      // bank a contents
  logic [8*`GBI2C_ENTRIES-1:0] bank_b;      // bank b contents
  logic [7:0]                  mb [2][14];  // expected banks
  logic [7:0]                  ctrl;        // expected control byte
  logic [7:0]                  q [$];       // bytes to send
  logic [7:0]                  r;           // byte read back
  logic                        ak;          // ack slot level
  int                          fail_count;
  int                          check_count;
  int                          cycles;
  logic [1:0]                  asel;        // address select pins
  logic [6:0]                  sid;         // slave address in use
  assign sda = !(sda_low || sda_oe);
  assign sid = {`GBI2C_ADDR_UPPER, asel};
  gbi2c_slave #(.FIFO_DEPTH(16)) u_gbi2c_slave (
    .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_transfer_mode_select(mode),
    .i_address_select_high(asel[1]), .i_address_select_low(asel[0]),
    .o_bank(bank), .o_bank_a(bank_a), .o_bank_b(bank_b));
  gbi2c_master_model u_gbi2c_master_model (
    .i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // clock generator
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // --------------------
  // compare, report and bus tasks
  // --------------------
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // expected byte at a pointer, read bank from control
  function automatic logic [7:0] exp_at(input logic [7:0] p);
    if (p == 8'h00)
      return ctrl;
    if (p > 8'h0E)
      return 8'hFF;
    return mb[ctrl[2]][p - 8'h01];
  endfunction
  // write transfer; standard mode sends the control byte first
  task automatic wr(input logic s);
    logic [7:0] p;
    p = s ? 8'h00 : q[0];
    u_gbi2c_master_model.start();
    u_gbi2c_master_model.byte_x({sid, 1'b0}, 1'b1, r, ak);
    chk8("address ack", 8'h00, {7'h00, ak});
    for (int k = 0; k < q.size(); k++)
    begin
      u_gbi2c_master_model.byte_x(q[k], 1'b1, r, ak);
      chk8("write ack", 8'h00, {7'h00, ak});
      if (s || k > 0)
      begin
        if (p == 8'h00)
          ctrl = q[k];
        else if (p <= 8'h0E)
          mb[ctrl[1]][p - 8'h01] = q[k];
        p = p + 8'h01;
      end
    end
    u_gbi2c_master_model.stop();
    chk8("bank select", {6'h00, ctrl[2:1]}, {6'h00, bank});
    for (int i = 0; i < 14; i++)
    begin
      chk8("bank a", mb[0][i], bank_a[8*i +: 8]);
      chk8("bank b", mb[1][i], bank_b[8*i +: 8]);
    end
  endtask
  // read n bytes; register mode writes the pointer then restarts
  task automatic rd(input logic s, input logic [7:0] a, input int n);
    logic [7:0] p;
    p = s ? 8'h01 : a;
    u_gbi2c_master_model.start();
    if (!s)
    begin
      u_gbi2c_master_model.byte_x({sid, 1'b0}, 1'b1, r, ak);
      u_gbi2c_master_model.byte_x(a, 1'b1, r, ak);
      u_gbi2c_master_model.start();
    end
    u_gbi2c_master_model.byte_x({sid, 1'b1}, 1'b1, r, ak);
    chk8("read address ack", 8'h00, {7'h00, ak});
    for (int k = 0; k < n; k++)
    begin
      u_gbi2c_master_model.byte_x(8'hFF, k == n - 1, r, ak);
      chk8("read data", exp_at(p), r);
      if (p != 8'hFF)
        p = p + 8'h01;
    end
    u_gbi2c_master_model.stop();
  endtask
  // cut a hang short
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      close_out();
    end
  end
  // --------------------
  // test sequence
  // --------------------
  initial
  begin
    i_rst = 1'b1;
    mode = 1'b0;
    asel = 2'b10;
    ctrl = 8'h00;
    mb = '{default: 8'h00};
    repeat (16) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clock);
    q = '{8'h0D, 8'h5A, 8'h5B, 8'h5C};
    wr(1'b0);
    $display("test reset and edge write done");
    q = '{8'h00, 8'h06};
    wr(1'b0);
    q = '{8'h01};
    for (int i = 0; i < 16; i++)
      q.push_back(8'h10 + 8'(i));
    wr(1'b0);
    $display("test bank change and long write done");
    rd(1'b0, 8'h0C, 5);
    rd(1'b0, 8'h00, 2);
    q = '{8'h00, 8'h02};
    wr(1'b0);
    rd(1'b0, 8'h0D, 3);
    q = '{8'h05, 8'h77, 8'h78};
    wr(1'b0);
    $display("test register reads done");
    u_gbi2c_master_model.start();
    u_gbi2c_master_model.byte_x({sid ^ 7'h01, 1'b0}, 1'b1, r, ak);
    chk8("foreign address nack", 8'h01, {7'h00, ak});
    u_gbi2c_master_model.stop();
    $display("test foreign address done");
    mode = 1'b1;
    repeat (4) @(negedge i_clock);
    rd(1'b1, 8'h00, 16);
    q = '{8'h04, 8'h21};
    wr(1'b1);
    rd(1'b1, 8'h00, 3);
    $display("test standard mode done");
    asel = 2'b01;
    repeat (4) @(negedge i_clock);
    rd(1'b1, 8'h00, 2);
    u_gbi2c_master_model.start();
    u_gbi2c_master_model.byte_x({`GBI2C_ADDR_UPPER, 2'b10, 1'b1}, 1'b1, r, ak);
    chk8("old address nack", 8'h01, {7'h00, ak});
    u_gbi2c_master_model.stop();
    $display("test address select done");
    close_out();
  end
endmodule
`default_nettype wire
